//--- src/ccx_pkg.sv
// shared constants, types and decode function for the clear/complement executor
package ccx_pkg;
  // apb register byte offsets
  localparam logic [7:0] CCX_OFF_INSTR = 8'h00;
  localparam logic [7:0] CCX_OFF_ACC = 8'h04;
  localparam logic [7:0] CCX_OFF_BANK = 8'h08;
  localparam logic [7:0] CCX_OFF_STATUS = 8'h0C;
  localparam logic [7:0] CCX_OFF_CTRL = 8'h10;
  localparam logic [7:0] CCX_OFF_INDEX = 8'h14;
  localparam logic [7:0] CCX_OFF_MADDR = 8'h18;
  localparam logic [7:0] CCX_OFF_MDATA = 8'h1C;
  localparam logic [7:0] CCX_OFF_WDOG = 8'h20;
  // status and control field positions
  localparam int CCX_ST_ZERO = 0;
  localparam int CCX_ST_SIGN = 1;
  localparam int CCX_ST_TO_N = 2;
  localparam int CCX_ST_PD_N = 3;
  localparam int CCX_CT_EXT = 0;
  localparam int CCX_CT_PDREQ = 1;
  localparam int CCX_BUSY_BIT = 16;
  // opcode patterns
  localparam logic [6:0] CCX_CLEAR_FILE_OP_HI = 7'h35;   // 0110 101
  localparam logic [5:0] CCX_COMPLEMENT_FILE_OP_HI = 6'h07;   // 0001 11
  localparam logic [15:0] CCX_WCLR_OP = 16'h0004;
  localparam logic [7:0] CCX_CLEAR_VAL = 8'h00;
  localparam logic [7:0] CCX_ACCESS_LIMIT = 8'h5F;
  localparam logic [3:0] CCX_ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0] CCX_ACCESS_LO_BANK = 4'h0;
  // reset values
  localparam logic [7:0] CCX_ACC_RST = 8'h00;
  localparam logic [3:0] CCX_BANK_RST = 4'h0;
  localparam logic [11:0] CCX_INDEX_RST = 12'h000;
  localparam logic [7:0] CCX_WDOG_RST = 8'h00;
  localparam int CCX_POST_W = 8;
  localparam logic [CCX_POST_W-1:0] CCX_POST_RST = 8'h00;
  localparam int CCX_MEM_WORDS = 4096;

  typedef enum logic [1:0] {
    CCX_K_NONE = 2'b00,
    CCX_K_CLEAR_FILE_OP = 2'b01,
    CCX_K_COMPLEMENT_FILE_OP = 2'b10,
    CCX_K_WCLR = 2'b11
  } ccx_kind_e;

  // quarter phases, gray along idle-q1-q2-q3-q4
  typedef enum logic [2:0] {
    CCX_S_IDLE = 3'b000,
    CCX_S_Q1 = 3'b001,
    CCX_S_Q2 = 3'b011,
    CCX_S_Q3 = 3'b010,
    CCX_S_Q4 = 3'b110
  } ccx_state_e;

  // classify a program word
  function automatic ccx_kind_e ccx_decode(input logic [15:0] op);
    if (op[15:9] == CCX_CLEAR_FILE_OP_HI) begin
      return CCX_K_CLEAR_FILE_OP;
    end else if (op[15:10] == CCX_COMPLEMENT_FILE_OP_HI) begin
      return CCX_K_COMPLEMENT_FILE_OP;
    end else if (op == CCX_WCLR_OP) begin
      return CCX_K_WCLR;
    end
    return CCX_K_NONE;
  endfunction
endpackage

//--- src/ccx_addr_map.sv
// file address resolution: access bank, banked and indexed literal offset
`timescale 1ns/1ps
module ccx_addr_map (
  input wire logic bank_bit,
  input wire logic [7:0] file_addr,
  input wire logic [3:0] bank_sel,
  input wire logic ext_en,
  input wire logic [11:0] index_base,
  output logic [11:0] full_addr
);
  import ccx_pkg::*;

  // bank bit picks the access bank or the selected bank
  always_comb begin
    if (bank_bit) begin
      full_addr = {bank_sel, file_addr};
    end else if (ext_en && file_addr <= CCX_ACCESS_LIMIT) begin
      full_addr = 12'(index_base + {4'h0, file_addr});
    end else if (file_addr <= CCX_ACCESS_LIMIT) begin
      full_addr = {CCX_ACCESS_LO_BANK, file_addr};
    end else begin
      full_addr = {CCX_ACCESS_HI_BANK, file_addr};
    end
  end
endmodule

//--- src/ccx_watchdog.sv
// watchdog counter with postscaler and active-low time-out and power-down bits
`timescale 1ns/1ps
module ccx_watchdog (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic pd_req,
  output logic [7:0] count,
  output logic [ccx_pkg::CCX_POST_W-1:0] post,
  output logic timeout_status_bit,
  output logic powerdown_status_bit
);
  import ccx_pkg::*;

  logic wrap;
  assign wrap = (count == 8'hFF) && (post == {CCX_POST_W{1'b1}});

  // postscaler then counter; clear resets both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post <= CCX_POST_RST;
      count <= CCX_WDOG_RST;
    end else if (clear) begin
      post <= CCX_POST_RST;
      count <= CCX_WDOG_RST;
    end else begin
      post <= CCX_POST_W'(post + 1'b1);
      if (post == {CCX_POST_W{1'b1}}) begin
        count <= 8'(count + 1'b1);
      end
    end
  end

  // status bits: clear sets them, events drop them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_status_bit <= 1'b1;
      powerdown_status_bit <= 1'b1;
    end else begin
      if (clear) begin
        timeout_status_bit <= 1'b1;
      end else if (wrap) begin
        timeout_status_bit <= 1'b0;
      end
      if (clear) begin
        powerdown_status_bit <= 1'b1;
      end else if (pd_req) begin
        powerdown_status_bit <= 1'b0;
      end
    end
  end

  property p_wclr_status;
    @(posedge pclk) disable iff (!presetn)
    clear |=> timeout_status_bit && powerdown_status_bit && count == 8'h00 && post == 8'h00;
  endproperty
  a_wclr_status: assert property (p_wclr_status) else $error("clear incomplete");
endmodule

//--- src/ccx_exec.sv
// apb-reached executor for the clear-file, watchdog-clear and complement-file ops
//
// Operation
// - clear-file writes 00h to the addressed register, sets zero flag only
// - bank bit 0 uses access bank, 1 uses bank select register
// - bank bit 0 with extended set uses indexed offset for addresses up to 5Fh
// - watchdog-clear resets watchdog counter and its postscaler
// - watchdog-clear sets time-out and power-down bits, nothing else
// - complement-file inverts the addressed register, updates sign and zero
// - complement destination 0 goes to accumulator, 1 back to the register
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module ccx_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import ccx_pkg::*;

  logic [7:0] mem [0:CCX_MEM_WORDS-1];
  ccx_state_e state_reg;
  ccx_kind_e kind_reg;
  logic [15:0] instr_reg;
  logic [7:0] acc_reg;
  logic [3:0] bank_reg;
  logic zero_reg;
  logic sign_reg;
  logic ext_reg;
  logic [11:0] index_reg;
  logic [11:0] maddr_reg;
  logic [7:0] operand_reg;
  logic [7:0] result_reg;
  logic [11:0] eff_addr;
  logic wd_clear;
  logic pd_pulse;
  logic [7:0] wd_count;
  logic [CCX_POST_W-1:0] wd_post;
  logic to_n;
  logic pd_n;
  logic setup;
  logic access;
  logic wr_acc;
  logic mapped;
  logic busy;
  logic [31:0] rd_next;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr_acc = access && pwrite;
  assign busy = (state_reg != CCX_S_IDLE);
  assign pready = 1'b1;

  // unmapped offsets answer with an error
  always_comb begin
    case (paddr)
      CCX_OFF_INSTR, CCX_OFF_ACC, CCX_OFF_BANK, CCX_OFF_STATUS, CCX_OFF_CTRL,
      CCX_OFF_INDEX, CCX_OFF_MADDR, CCX_OFF_MDATA, CCX_OFF_WDOG: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = access && !mapped;

  ccx_addr_map ccx_addr_map_inst (
    .bank_bit(instr_reg[8]),
    .file_addr(instr_reg[7:0]),
    .bank_sel(bank_reg),
    .ext_en(ext_reg),
    .index_base(index_reg),
    .full_addr(eff_addr)
  );

  ccx_watchdog ccx_watchdog_inst (
    .pclk(pclk),
    .presetn(presetn),
    .clear(wd_clear),
    .pd_req(pd_pulse),
    .count(wd_count),
    .post(wd_post),
    .timeout_status_bit(to_n),
    .powerdown_status_bit(pd_n)
  );

  // watchdog clear acts in the process quarter
  assign wd_clear = (state_reg == CCX_S_Q3) && (kind_reg == CCX_K_WCLR);
  assign pd_pulse = wr_acc && (paddr == CCX_OFF_CTRL) && pwdata[CCX_CT_PDREQ];

  // quarter phase sequencer, started by an instruction write when idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= CCX_S_IDLE;
    end else begin
      case (state_reg)
        CCX_S_IDLE: begin
          if (wr_acc && paddr == CCX_OFF_INSTR) begin
            state_reg <= CCX_S_Q1;
          end
        end
        CCX_S_Q1: state_reg <= CCX_S_Q2;
        CCX_S_Q2: state_reg <= CCX_S_Q3;
        CCX_S_Q3: state_reg <= CCX_S_Q4;
        default: state_reg <= CCX_S_IDLE;
      endcase
    end
  end

  // program word latch, refused while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_reg <= 16'h0000;
    end else if (!busy && wr_acc && paddr == CCX_OFF_INSTR) begin
      instr_reg <= pwdata[15:0];
    end
  end

  // q1 decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kind_reg <= CCX_K_NONE;
    end else if (state_reg == CCX_S_Q1) begin
      kind_reg <= ccx_decode(instr_reg);
    end
  end

  // q2 operand read, q3 process
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand_reg <= 8'h00;
      result_reg <= 8'h00;
    end else begin
      if (state_reg == CCX_S_Q2 && kind_reg != CCX_K_WCLR) begin
        operand_reg <= mem[eff_addr];
      end
      if (state_reg == CCX_S_Q3) begin
        result_reg <= (kind_reg == CCX_K_CLEAR_FILE_OP) ? CCX_CLEAR_VAL : ~operand_reg;
      end
    end
  end

  // data memory: q4 write wins over software access
  always_ff @(posedge pclk) begin
    if (state_reg == CCX_S_Q4 &&
        (kind_reg == CCX_K_CLEAR_FILE_OP || (kind_reg == CCX_K_COMPLEMENT_FILE_OP && instr_reg[9]))) begin
      mem[eff_addr] <= result_reg;
    end else if (!busy && wr_acc && paddr == CCX_OFF_MDATA) begin
      mem[maddr_reg] <= pwdata[7:0];
    end
  end

  // accumulator: complement with destination 0, else software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= CCX_ACC_RST;
    end else if (state_reg == CCX_S_Q4 && kind_reg == CCX_K_COMPLEMENT_FILE_OP && !instr_reg[9]) begin
      acc_reg <= result_reg;
    end else if (wr_acc && paddr == CCX_OFF_ACC) begin
      acc_reg <= pwdata[7:0];
    end
  end

  // zero and sign flags; execution wins over a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_reg <= 1'b0;
      sign_reg <= 1'b0;
    end else if (state_reg == CCX_S_Q4 && kind_reg == CCX_K_CLEAR_FILE_OP) begin
      zero_reg <= 1'b1;
    end else if (state_reg == CCX_S_Q4 && kind_reg == CCX_K_COMPLEMENT_FILE_OP) begin
      zero_reg <= (result_reg == 8'h00);
      sign_reg <= result_reg[7];
    end else if (wr_acc && paddr == CCX_OFF_STATUS) begin
      zero_reg <= pwdata[CCX_ST_ZERO];
      sign_reg <= pwdata[CCX_ST_SIGN];
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_reg <= CCX_BANK_RST;
      ext_reg <= 1'b0;
      index_reg <= CCX_INDEX_RST;
      maddr_reg <= 12'h000;
    end else if (wr_acc && !busy) begin
      case (paddr)
        CCX_OFF_BANK: bank_reg <= pwdata[3:0];
        CCX_OFF_CTRL: ext_reg <= pwdata[CCX_CT_EXT];
        CCX_OFF_INDEX: index_reg <= pwdata[11:0];
        CCX_OFF_MADDR: maddr_reg <= pwdata[11:0];
        default: ;
      endcase
    end
  end

  // read mux, captured in the setup cycle
  always_comb begin
    rd_next = 32'h0000_0000;
    case (paddr)
      CCX_OFF_INSTR: rd_next = {15'h0000, busy, instr_reg};
      CCX_OFF_ACC: rd_next = {24'h000000, acc_reg};
      CCX_OFF_BANK: rd_next = {28'h0000000, bank_reg};
      CCX_OFF_STATUS: rd_next = {28'h0000000, pd_n, to_n, sign_reg, zero_reg};
      CCX_OFF_CTRL: rd_next = {31'h00000000, ext_reg};
      CCX_OFF_INDEX: rd_next = {20'h00000, index_reg};
      CCX_OFF_MADDR: rd_next = {20'h00000, maddr_reg};
      CCX_OFF_MDATA: rd_next = {24'h000000, mem[maddr_reg]};
      CCX_OFF_WDOG: rd_next = {16'h0000, wd_post, wd_count};
      default: rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= rd_next;
    end
  end

  // checks
  property p_clear_file_op_zero;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == CCX_S_Q4 && kind_reg == CCX_K_CLEAR_FILE_OP) |=> zero_reg && sign_reg == $past(sign_reg);
  endproperty
  a_clear_file_op_zero: assert property (p_clear_file_op_zero) else $error("clear-file flags wrong");

  property p_bank_sel;
    @(posedge pclk) disable iff (!presetn)
    instr_reg[8] |-> eff_addr == {bank_reg, instr_reg[7:0]};
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("banked address wrong");

  property p_indexed;
    @(posedge pclk) disable iff (!presetn)
    (!instr_reg[8] && ext_reg && instr_reg[7:0] <= 8'h5F)
      |-> eff_addr == 12'(index_reg + {4'h0, instr_reg[7:0]});
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  property p_wclr_count;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == CCX_S_Q3 && kind_reg == CCX_K_WCLR) |=> wd_count == 8'h00 && wd_post == 8'h00;
  endproperty
  a_wclr_count: assert property (p_wclr_count) else $error("watchdog not cleared");

  property p_wclr_flags;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == CCX_S_Q3 && kind_reg == CCX_K_WCLR) |=> $stable(zero_reg) && to_n && pd_n;
  endproperty
  a_wclr_flags: assert property (p_wclr_flags) else $error("clear flags wrong");

  property p_complement_file_op_result;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == CCX_S_Q2 && kind_reg == CCX_K_COMPLEMENT_FILE_OP) |=> ##1
      result_reg == ~$past(operand_reg, 1) ##1 sign_reg == $past(result_reg[7]);
  endproperty
  a_complement_file_op_result: assert property (p_complement_file_op_result) else $error("complement wrong");

  property p_complement_file_op_acc;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == CCX_S_Q4 && kind_reg == CCX_K_COMPLEMENT_FILE_OP && !instr_reg[9])
      |=> acc_reg == $past(result_reg);
  endproperty
  a_complement_file_op_acc: assert property (p_complement_file_op_acc) else $error("accumulator not written");

  property p_complement_file_op_file;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == CCX_S_Q4 && kind_reg == CCX_K_COMPLEMENT_FILE_OP && instr_reg[9]) |=> $stable(acc_reg);
  endproperty
  a_complement_file_op_file: assert property (p_complement_file_op_file) else $error("accumulator disturbed");

  property p_one_cycle;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == CCX_S_Q1) |=> state_reg == CCX_S_Q2 ##1 state_reg == CCX_S_Q3
      ##1 state_reg == CCX_S_Q4 ##1 state_reg == CCX_S_IDLE;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("quarter sequence broken");

  property p_complement_file_op_zero;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == CCX_S_Q4 && kind_reg == CCX_K_COMPLEMENT_FILE_OP)
      |=> zero_reg == ($past(result_reg) == 8'h00);
  endproperty
  a_complement_file_op_zero: assert property (p_complement_file_op_zero) else $error("zero flag wrong");

  property p_clear_file_op_result;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == CCX_S_Q3 && kind_reg == CCX_K_CLEAR_FILE_OP) |=> result_reg == CCX_CLEAR_VAL;
  endproperty
  a_clear_file_op_result: assert property (p_clear_file_op_result) else $error("clear value wrong");

  // program word must not move while its quarters run
  property p_instr_hold;
    @(posedge pclk) disable iff (!presetn)
    busy |=> $stable(instr_reg);
  endproperty
  a_instr_hold: assert property (p_instr_hold) else $error("word changed");

  property p_wclr_noread;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == CCX_S_Q2 && kind_reg == CCX_K_WCLR) |=> $stable(operand_reg);
  endproperty
  a_wclr_noread: assert property (p_wclr_noread) else $error("operand was read");

  c_clear_file_op: cover property (@(posedge pclk) state_reg == CCX_S_Q4 && kind_reg == CCX_K_CLEAR_FILE_OP);
  c_complement_file_op_w: cover property (@(posedge pclk) state_reg == CCX_S_Q4 && kind_reg == CCX_K_COMPLEMENT_FILE_OP
    && !instr_reg[9]);
  c_wclr: cover property (@(posedge pclk) wd_clear);
  c_indexed: cover property (@(posedge pclk) state_reg == CCX_S_Q2 && ext_reg && !instr_reg[8]);
  c_refused: cover property (@(posedge pclk) busy && wr_acc && paddr == CCX_OFF_INSTR);
endmodule

//--- verification/clear_complement_exec_tb.sv
// self-checking bench for the clear/complement executor over apb
`timescale 1ns/1ps
module clear_complement_exec_tb;
  import ccx_pkg::*;
  // one program word with its setup and expected results
  typedef struct packed {
    logic [15:0] op;
    logic [3:0] bank;
    logic ext;
    logic [7:0] pre;
    logic [1:0] st0;
    logic [7:0] mem;
    logic [7:0] acc;
    logic [1:0] st;
  } cce_row_s;
  localparam logic [11:0] IDX = 12'h123;
  localparam logic [7:0] ACC0 = 8'hA5;
  logic pclk = 1'b0;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  logic err;
  int err_count = 0;
  int total_checks = 0;
  cce_row_s rows [8];

  ccx_exec ccx_exec_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  // 40 mhz clock
  always #12.5 pclk = ~pclk;

  // verdict and end of run
  task automatic end_of_test();
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // compare a data word
  task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // compare a single flag
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // one apb transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read a register and compare the masked word
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
                       input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk_word(nm, exp, rd & m);
  endtask

  // start a program word and let its four quarter phases run
  task automatic exec(input logic [15:0] op);
    apb(1'b1, CCX_OFF_INSTR, {16'h0000, op});
    repeat (4) @(posedge pclk);
  endtask

  // expected data memory address of a register-addressed word
  function automatic logic [11:0] fa(input logic [15:0] op, input logic [3:0] b,
                                     input logic e);
    if (op[8]) begin
      return {b, op[7:0]};
    end
    if (op[7:0] <= 8'h5F) begin
      return e ? IDX + {4'h0, op[7:0]} : {4'h0, op[7:0]};
    end
    return {4'hF, op[7:0]};
  endfunction

  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    end_of_test();
  end

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rows[0] = '{16'h6B42, 4'h3, 1'b0, 8'h5A, 2'b10, 8'h00, ACC0, 2'b11};
    rows[1] = '{16'h6A10, 4'h0, 1'b0, 8'hFF, 2'b00, 8'h00, ACC0, 2'b01};
    rows[2] = '{16'h6A80, 4'h0, 1'b0, 8'h12, 2'b10, 8'h00, ACC0, 2'b11};
    rows[3] = '{16'h1D13, 4'h2, 1'b0, 8'h13, 2'b00, 8'h13, 8'hEC, 2'b10};
    rows[4] = '{16'h1F7F, 4'h5, 1'b0, 8'hFF, 2'b10, 8'h00, ACC0, 2'b01};
    rows[5] = '{16'h1E5F, 4'h0, 1'b1, 8'h0F, 2'b00, 8'hF0, ACC0, 2'b10};
    rows[6] = '{16'h1C60, 4'h0, 1'b1, 8'h80, 2'b01, 8'h80, 8'h7F, 2'b00};
    rows[7] = '{16'h6A00, 4'h0, 1'b1, 8'h33, 2'b00, 8'h00, ACC0, 2'b01};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // table of clear and complement words
    foreach (rows[i]) begin
      apb(1'b1, CCX_OFF_BANK, {28'h0, rows[i].bank});
      apb(1'b1, CCX_OFF_CTRL, {31'h0, rows[i].ext});
      apb(1'b1, CCX_OFF_INDEX, {20'h0, IDX});
      apb(1'b1, CCX_OFF_MADDR, {20'h0, fa(rows[i].op, rows[i].bank, rows[i].ext)});
      apb(1'b1, CCX_OFF_MDATA, {24'h0, rows[i].pre});
      apb(1'b1, CCX_OFF_ACC, {24'h0, ACC0});
      apb(1'b1, CCX_OFF_STATUS, {30'h0, rows[i].st0});
      exec(rows[i].op);
      rdchk(CCX_OFF_MDATA, 32'hFF, {24'h0, rows[i].mem}, "mem");
      rdchk(CCX_OFF_ACC, 32'hFF, {24'h0, rows[i].acc}, "acc");
      rdchk(CCX_OFF_STATUS, 32'h3, {30'h0, rows[i].st}, "flags");
    end
    // watchdog runs, then power-down request, then clear while busy
    repeat (600) @(posedge pclk);
    apb(1'b0, CCX_OFF_WDOG, 32'h0000_0000);
    chk_bit("wdog_running", 1'b1, |rd[7:0]);
    apb(1'b1, CCX_OFF_STATUS, 32'h0000_0003);
    apb(1'b1, CCX_OFF_CTRL, 32'h0000_0002);
    rdchk(CCX_OFF_STATUS, 32'hF, 32'h0000_0007, "pd_set");
    apb(1'b1, CCX_OFF_INSTR, {16'h0000, CCX_WCLR_OP});
    rdchk(CCX_OFF_INSTR, 32'h1_FFFF, 32'h0001_0004, "busy");
    repeat (2) @(posedge pclk);
    rdchk(CCX_OFF_WDOG, 32'hFF, 32'h0000_0000, "wdog_count");
    chk_bit("post_small", 1'b1, rd[15:8] < 8'h08);
    rdchk(CCX_OFF_STATUS, 32'hF, 32'h0000_000F, "wclr_flags");
    rdchk(CCX_OFF_INSTR, 32'h1_0000, 32'h0000_0000, "idle");
    // unmapped address is refused
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk_bit("slverr", 1'b1, err);
    chk_word("unmapped", 32'h0000_0000, rd);
    // word written while busy is refused; unknown word runs as a no-op
    apb(1'b1, CCX_OFF_INSTR, {16'h0000, CCX_WCLR_OP});
    apb(1'b1, CCX_OFF_INSTR, 32'h0000_6A00);
    rdchk(CCX_OFF_INSTR, 32'h1_FFFF, 32'h0000_0004, "refused");
    exec(16'h0000);
    rdchk(CCX_OFF_ACC, 32'hFF, {24'h0, ACC0}, "nop_acc");
    rdchk(CCX_OFF_STATUS, 32'hF, 32'h0000_000F, "nop_flags");
    // second reset in mid-run and reset values
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(CCX_OFF_ACC, 32'hFFFF_FFFF, {24'h0, CCX_ACC_RST}, "acc_rst");
    rdchk(CCX_OFF_BANK, 32'hFFFF_FFFF, {28'h0, CCX_BANK_RST}, "bank_rst");
    rdchk(CCX_OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_000C, "status_rst");
    rdchk(CCX_OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, "ctrl_rst");
    rdchk(CCX_OFF_INDEX, 32'hFFFF_FFFF, {20'h0, CCX_INDEX_RST}, "index_rst");
    end_of_test();
  end
endmodule
